//--- test_windowed_watchdog_timer.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
   $display("MISMATCH %0t wrong value", $time); end end
module test_windowed_watchdog_timer;
   import wwdt_pkg::*;
   logic clk_in = 1'b0;
   logic srst_in = 1'b1;
   logic enable_in = 1'b0;
   logic window_en_in = 1'b0;
   logic service_in = 1'b0;
   logic fault_clr_in = 1'b0;
   logic [3:0] prescale_in = 4'h0;
   logic [31:0] window_open_in = 32'h0000_0002;
   logic [31:0] timeout_in = 32'h0000_0005;
   wwdt_resp_type resp_in = WWDT_RESP_NONE;
   logic irq_out;
   logic sys_rst_req_out;
   logic redirect_out;
   logic timeout_flag_out;
   logic early_flag_out;
   logic [31:0] redirect_addr_out;
   logic [31:0] count_out;
   int failures = 0;
   int num_checks = 0;
   always #25 clk_in = ~clk_in;
   wwdt_top wwdt_top_inst (
      .clk_in(clk_in),
      .srst_in(srst_in),
      .enable_in(enable_in),
      .prescale_in(prescale_in),
      .window_en_in(window_en_in),
      .window_open_in(window_open_in),
      .timeout_in(timeout_in),
      .resp_in(resp_in),
      .service_in(service_in),
      .fault_clr_in(fault_clr_in),
      .irq_out(irq_out),
      .sys_rst_req_out(sys_rst_req_out),
      .redirect_out(redirect_out),
      .redirect_addr_out(redirect_addr_out),
      .timeout_flag_out(timeout_flag_out),
      .early_flag_out(early_flag_out),
      .count_out(count_out)
   );
   task automatic tick(int n); repeat (n) @(negedge clk_in); endtask
   task automatic conclude;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic expiry_test;
      for (int r = 0; r < 4; r++) begin
         resp_in = wwdt_resp_type'(r); enable_in = 0; fault_clr_in = 1; tick(1);
         fault_clr_in = 0; enable_in = 1; tick(5); `CHK(timeout_flag_out, 1'b0)
         tick(1);
         `CHK(timeout_flag_out, 1'b1)
         `CHK(irq_out, r[0])
         `CHK(sys_rst_req_out, r[1])
         `CHK(redirect_out, (r != 0))
         `CHK(redirect_addr_out, WWDT_SAFE_ADDR_DEF)
         tick(1);
         `CHK(sys_rst_req_out, 1'b0)
      end
      $display("expiry test done");
   endtask
   task automatic service_test;
      // Two services back to back, then a free run of three counts
      fault_clr_in = 1; service_in = 1; tick(2); `CHK(count_out, 32'h0)
      fault_clr_in = 0; service_in = 0; tick(3); `CHK(count_out, 32'h3)
      `CHK(timeout_flag_out, 1'b0) $display("service test done");
   endtask
   task automatic window_test;
      window_en_in = 1; service_in = 1; tick(1); `CHK(count_out, 32'h0)
      `CHK(early_flag_out, 1'b0) tick(1); service_in = 0; `CHK(early_flag_out, 1'b1)
      `CHK(redirect_out, 1'b1) $display("window test done");
   endtask
   task automatic prescale_test;
      window_en_in = 1'b0;
      enable_in = 1'b0;
      fault_clr_in = 1'b1;
      resp_in = WWDT_RESP_IRQ;
      prescale_in = 4'h2;
      timeout_in = 32'h0000_0003;
      tick(1);
      fault_clr_in = 1'b0;
      enable_in = 1'b1;
      tick(4);
      `CHK(count_out, 32'h0000_0001)
      tick(1);
      `CHK(count_out, 32'h0000_0002)
      tick(4);
      `CHK(count_out, 32'h0000_0003)
      `CHK(timeout_flag_out, 1'b0)
      tick(1);
      `CHK(timeout_flag_out, 1'b1)
      `CHK(irq_out, 1'b1)
      `CHK(sys_rst_req_out, 1'b0)
      `CHK(count_out, 32'h0000_0000)
      $display("prescale test done");
   endtask
   task automatic reset_test;
      srst_in = 1'b1;
      tick(2);
      `CHK(irq_out, 1'b0)
      `CHK(timeout_flag_out, 1'b0)
      `CHK(count_out, 32'h0000_0000)
      srst_in = 1'b0;
      prescale_in = 4'h0;
      timeout_in = 32'h0000_0005;
      tick(1);
      `CHK(count_out, 32'h0000_0001)
      tick(1);
      `CHK(count_out, 32'h0000_0002)
      $display("reset test done");
   endtask
   initial begin
      tick(4);
      srst_in = 1'b0;
      expiry_test();
      service_test();
      window_test();
      prescale_test();
      reset_test();
      conclude();
   end
endmodule
`default_nettype wire

//--- wwdt_checker.sv
`timescale 1ns/1ps
`default_nettype none
module wwdt_checker #(
   parameter int CNT_W = 32
) (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic enable_in,
   input wire logic window_en_in,
   input wire logic service_in,
   input wire logic irq_out,
   input wire logic sys_rst_req_out,
   input wire logic redirect_out,
   input wire logic timeout_flag_out,
   input wire logic early_flag_out,
   input wire logic [CNT_W-1:0] window_open_in,
   input wire logic [CNT_W-1:0] timeout_in,
   input wire logic [CNT_W-1:0] count_out,
   input wire logic [3:0] prescale_in,
   input wire wwdt_pkg::wwdt_resp_type resp_in
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (srst_in);
   wire logic fire = enable_in && count_out >= timeout_in;
   wire logic early = enable_in && service_in && window_en_in && count_out < window_open_in;
   wire logic at_top = (count_out == {CNT_W{1'b1}});
   count_step_a: assert property (enable_in && !service_in && !fire && !at_top
      && prescale_in == 4'h0 |=> count_out == $past(count_out) + 1) else $error("bad step");
   expire_flag_a: assert property (fire |=> timeout_flag_out) else $error("bad expiry");
   irq_set_a: assert property (fire && resp_in[0] |=> irq_out) else $error("bad irq");
   safe_jump_a: assert property (sys_rst_req_out |-> redirect_out) else $error("bad jump");
   early_fail_a: assert property (early |=> early_flag_out) else $error("bad early");
   svc_restart_a: assert property (service_in && !fire && !early |=> count_out == 0)
      else $error("bad restart");
   cover property (early);
   cover property (sys_rst_req_out);
   cover property (fire && resp_in[0]);
   cover property (fire && prescale_in != 4'h0);
endmodule
bind wwdt_top wwdt_checker #(.CNT_W(CNT_W)) wwdt_checker_inst (.*);
`default_nettype wire

//--- wwdt_pkg.sv
package wwdt_pkg;
   localparam int WWDT_CNT_W = 32;
   localparam int WWDT_PRE_W = 4;
   localparam logic [31:0] WWDT_CNT_RST = 32'h0000_0000;
   localparam logic [3:0] WWDT_PRE_RST = 4'h0;
   localparam logic [31:0] WWDT_SAFE_ADDR_DEF = 32'h0000_0000;
   typedef enum logic [1:0] {
      WWDT_RESP_NONE,
      WWDT_RESP_IRQ,
      WWDT_RESP_RST,
      WWDT_RESP_BOTH
   } wwdt_resp_type;
endpackage

//--- wwdt_top.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RULE1: A 32-bit counter runs freely once enabled, advanced by the prescaled clock.
// RULE2: Software must service the watchdog before each timeout interval ends.
// RULE3: If no service arrives by the end of the timeout interval a timeout is declared.
// RULE4: A timeout raises an interrupt, a reset request, or both, as configured.
// RULE5: Either response steers execution to a fixed known-good address.
// RULE6: In windowed mode a service before the window opens counts as a failure.
// RULE7: A valid service restarts the counter from zero.
module wwdt_top #(
   parameter int CNT_W = 32,
   parameter logic [31:0] SAFE_ADDR = wwdt_pkg::WWDT_SAFE_ADDR_DEF
) (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic enable_in,
   input wire logic [wwdt_pkg::WWDT_PRE_W-1:0] prescale_in,
   input wire logic window_en_in,
   input wire logic [CNT_W-1:0] window_open_in,
   input wire logic [CNT_W-1:0] timeout_in,
   input wire wwdt_pkg::wwdt_resp_type resp_in,
   input wire logic service_in,
   input wire logic fault_clr_in,
   output logic irq_out,
   output logic sys_rst_req_out,
   output logic redirect_out,
   output logic [31:0] redirect_addr_out,
   output logic timeout_flag_out,
   output logic early_flag_out,
   output logic [CNT_W-1:0] count_out
);
   import wwdt_pkg::*;

   // Divider wide enough for the largest prescale setting
   localparam int PRE_CNT_W = 16;
   localparam logic [PRE_CNT_W-1:0] PRE_ONE = 16'h0001;

   generate
      if (CNT_W != WWDT_CNT_W) begin : g_cnt_w_check
         $error("wwdt_top: CNT_W must equal the 32-bit counter width");
      end
      if ((1 << WWDT_PRE_W) > PRE_CNT_W) begin : g_pre_w_check
         $error("wwdt_top: divider too narrow for the prescale range");
      end
   endgenerate

   logic [PRE_CNT_W-1:0] pre_ff;
   logic [PRE_CNT_W-1:0] nxt_pre;
   logic [PRE_CNT_W-1:0] pre_mask;
   logic tick;
   logic [CNT_W-1:0] cnt_ff;
   logic [CNT_W-1:0] nxt_cnt;
   logic cnt_at_top;
   logic expired;
   logic svc_req;
   logic early;
   logic valid_svc;
   logic early_fail;
   logic fail;
   logic resp_irq;
   logic resp_rst;
   logic fail_irq;
   logic fail_rst;
   logic timeout_flag_ff;
   logic nxt_timeout_flag;
   logic early_flag_ff;
   logic nxt_early_flag;
   logic irq_ff;
   logic nxt_irq;
   logic sys_rst_req_ff;
   logic nxt_sys_rst_req;
   logic redirect_ff;
   logic nxt_redirect;
   logic [31:0] redirect_addr_ff;

   // Divide by 2**prescale_in; zero gives a tick every cycle
   always_comb begin
      pre_mask = (PRE_ONE << prescale_in) - PRE_ONE;
      tick = 1'b0;
      if (enable_in) begin
         tick = ((pre_ff & pre_mask) == '0);
      end
   end

   // Divider restarts with the counter, so each interval starts at divider phase zero and ticks on its first cycle
   always_comb begin
      nxt_pre = pre_ff + PRE_ONE;
      if (!enable_in || valid_svc || fail) begin
         nxt_pre = '0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         pre_ff <= '0;
      end else begin
         pre_ff <= nxt_pre;
      end
   end

   always_comb begin
      cnt_at_top = (cnt_ff == {CNT_W{1'b1}});
      expired = enable_in && (cnt_ff >= timeout_in); // RULE3
      svc_req = enable_in && service_in;
      early = window_en_in && (cnt_ff < window_open_in); // RULE6
      valid_svc = svc_req && !early;
      early_fail = svc_req && early; // RULE6
      fail = expired || early_fail;
   end

   always_comb begin
      resp_irq = (resp_in == WWDT_RESP_IRQ) || (resp_in == WWDT_RESP_BOTH);
      resp_rst = (resp_in == WWDT_RESP_RST) || (resp_in == WWDT_RESP_BOTH);
      fail_irq = fail && resp_irq; // RULE4
      fail_rst = fail && resp_rst; // RULE4
   end

   // A fault restarts the count too, so one fault fires one response
   always_comb begin
      nxt_cnt = cnt_ff;
      if (!enable_in) begin
         nxt_cnt = CNT_W'(WWDT_CNT_RST);
      end else if (valid_svc) begin
         nxt_cnt = CNT_W'(WWDT_CNT_RST); // RULE7
      end else if (fail) begin
         nxt_cnt = CNT_W'(WWDT_CNT_RST);
      end else if (tick && !cnt_at_top) begin
         // Saturates rather than wrapping, so a late timeout still fires
         nxt_cnt = cnt_ff + CNT_W'(1); // RULE1
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         cnt_ff <= CNT_W'(WWDT_CNT_RST);
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

   // Sticky flags: a new fault in the clear cycle wins
   always_comb begin
      nxt_timeout_flag = timeout_flag_ff;
      if (fault_clr_in) begin
         nxt_timeout_flag = 1'b0;
      end
      if (expired) begin
         nxt_timeout_flag = 1'b1; // RULE3
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         timeout_flag_ff <= 1'b0;
      end else begin
         timeout_flag_ff <= nxt_timeout_flag;
      end
   end

   always_comb begin
      nxt_early_flag = early_flag_ff;
      if (fault_clr_in) begin
         nxt_early_flag = 1'b0;
      end
      if (early_fail && !expired) begin
         nxt_early_flag = 1'b1; // RULE6
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         early_flag_ff <= 1'b0;
      end else begin
         early_flag_ff <= nxt_early_flag;
      end
   end

   always_comb begin
      nxt_irq = irq_ff;
      if (fault_clr_in) begin
         nxt_irq = 1'b0;
      end
      if (fail_irq) begin
         nxt_irq = 1'b1; // RULE4
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= nxt_irq;
      end
   end

   // Reset request and redirect are one-cycle pulses
   always_comb begin
      nxt_sys_rst_req = fail_rst; // RULE4
      nxt_redirect = fail_irq || fail_rst; // RULE5
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         sys_rst_req_ff <= 1'b0;
      end else begin
         sys_rst_req_ff <= nxt_sys_rst_req;
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         redirect_ff <= 1'b0;
      end else begin
         redirect_ff <= nxt_redirect;
      end
   end

   // Address is constant but held in a flop so the output is registered
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         redirect_addr_ff <= 32'h0000_0000;
      end else begin
         redirect_addr_ff <= SAFE_ADDR; // RULE5
      end
   end

   assign irq_out = irq_ff;
   assign sys_rst_req_out = sys_rst_req_ff;
   assign redirect_out = redirect_ff;
   assign redirect_addr_out = redirect_addr_ff;
   assign timeout_flag_out = timeout_flag_ff;
   assign early_flag_out = early_flag_ff;
   assign count_out = cnt_ff;
endmodule
`default_nettype wire
